// ==== hdl/scp_device.sv ====
// converter end: serial port slave, registers, straps, pattern source
`timescale 1ns/1ns
module scp_device (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial link
    scp_link_if.device link,
    // converter side
    input wire logic encode_tick,
    input wire logic [15:0] adc_word,
    input wire logic power_down_pin,
    output logic [15:0] out_word,
    output logic [7:0] bank_one_test_mode,
    output logic [7:0] bank_two_test_mode,
    output logic two_lane_mode,
    output logic power_down,
    output logic serial_mode
);
    typedef struct packed {
        logic [1:0] sclk_s1;
        logic [1:0] strap_wait;
        logic [1:0] cs1_s;
        logic [1:0] cs2_s;
        logic [1:0] sdio_s;
        logic sclk_last;
        logic cs_last;
        logic strapped;
        logic pattern_strap;
        logic lane_strap;
        scp_pkg::scp_phase_type phase;
        logic [4:0] bit_cnt;
        logic [15:0] instr;
        logic [7:0] shreg;
        logic [12:0] addr;
        logic [2:0] bytes_left;
        logic stream;
        logic sel1;
        logic sel2;
        logic driving;
        logic sdo;
        logic [7:0] port_cfg;
        logic [7:0] tm1;
        logic [7:0] tm2;
        logic [8:0] pn9;
        logic [22:0] pn23;
        logic [15:0] out_word;
    } scp_dev_state_type;

    scp_dev_state_type r;
    scp_dev_state_type next_r;

    function automatic logic [7:0] swap_bits(input logic [7:0] v);
        logic [7:0] o;
        o = '0;
        for (int i = 0; i < 8; i++) begin
            o[i] = v[7 - i];
        end
        return o;
    endfunction

    logic sclk_q;
    logic cs1_q;
    logic cs2_q;
    logic any_sel;
    logic rise;
    logic fall;
    logic lsb;
    logic [7:0] rd_val;
    logic [7:0] wr_val;

    always_comb begin
        next_r = r;
        next_r.sclk_s1 = {r.sclk_s1[0], link.sclk};
        next_r.cs1_s = {r.cs1_s[0], link.bank_one_select_n};
        next_r.cs2_s = {r.cs2_s[0], link.bank_two_select_n};
        next_r.sdio_s = {r.sdio_s[0], link.sdio};
        sclk_q = r.sclk_s1[1];
        cs1_q = r.cs1_s[1];
        cs2_q = r.cs2_s[1];
        next_r.sclk_last = sclk_q;
        any_sel = !cs1_q || !cs2_q;
        next_r.cs_last = any_sel;
        rise = sclk_q && !r.sclk_last && any_sel;
        fall = !sclk_q && r.sclk_last && any_sel;
        lsb = r.port_cfg[scp_pkg::cfg_lsb_first_bit];
        rd_val = 8'h00;
        wr_val = lsb ? swap_bits(r.shreg) : r.shreg;
        case (r.addr)
            scp_pkg::port_cfg_addr: rd_val = r.port_cfg;
            scp_pkg::chip_id_addr: rd_val = scp_pkg::chip_id_value;
            scp_pkg::test_mode_addr: rd_val = r.sel1 ? r.tm1 : r.tm2;
            default: rd_val = 8'h00;
        endcase
        if (lsb) begin
            rd_val = swap_bits(rd_val);
        end
        // straps caught once the synchronisers have settled
        if (!r.strapped) begin
            next_r.strap_wait = r.strap_wait + 2'd1;
            if (r.strap_wait == 2'(scp_pkg::strap_settle)) begin
                next_r.strapped = 1'b1;
                next_r.pattern_strap = cs1_q && cs2_q && sclk_q;
                next_r.lane_strap = r.sdio_s[1];
            end
        end
        if (r.phase == scp_pkg::scp_idle_type_s && rise) begin
            next_r.phase = scp_pkg::scp_instr_s;
            next_r.bit_cnt = 5'd1;
            next_r.instr = {15'd0, r.sdio_s[1]};
            next_r.sel1 = !cs1_q;
            next_r.sel2 = !cs2_q;
        end else if (r.phase == scp_pkg::scp_instr_s && rise) begin
            next_r.instr = {r.instr[14:0], r.sdio_s[1]};
            next_r.bit_cnt = r.bit_cnt + 5'd1;
            if (r.bit_cnt == 5'(scp_pkg::instr_bits - 1)) begin
                next_r.phase = scp_pkg::scp_data_s;
                next_r.bit_cnt = '0;
                next_r.addr = {r.instr[11:0], r.sdio_s[1]};
                next_r.stream = (r.instr[13:12] == 2'b11);
                next_r.bytes_left = 3'(r.instr[13:12]) + 3'd1;
                next_r.driving = r.instr[14];
            end
        end else if (r.phase == scp_pkg::scp_data_s && rise) begin
            next_r.shreg = {r.shreg[6:0], r.sdio_s[1]};
            next_r.bit_cnt = r.bit_cnt + 5'd1;
            if (r.bit_cnt == 5'(scp_pkg::word_bits - 1)) begin
                next_r.bit_cnt = '0;
                next_r.addr = r.addr - 13'd1;
                next_r.bytes_left = r.bytes_left - 3'd1;
                if (!r.instr[15]) begin
                    wr_val = lsb ? swap_bits({r.shreg[6:0], r.sdio_s[1]})
                                 : {r.shreg[6:0], r.sdio_s[1]};
                    if (r.addr == scp_pkg::port_cfg_addr) begin
                        next_r.port_cfg = wr_val;
                    end
                    if (r.addr == scp_pkg::test_mode_addr) begin
                        if (r.sel1) next_r.tm1 = wr_val;
                        if (r.sel2) next_r.tm2 = wr_val;
                    end
                end
                if (!r.stream && r.bytes_left == 3'd1) begin
                    next_r.phase = scp_pkg::scp_idle_type_s;
                    next_r.driving = 1'b0;
                end
            end
        end
        if (r.phase == scp_pkg::scp_data_s && r.instr[15] && fall) begin
            next_r.sdo = rd_val[3'(7 - r.bit_cnt[2:0])];
        end
        if (!any_sel) begin
            next_r.driving = 1'b0;
        end else if (next_r.phase == scp_pkg::scp_data_s
                     && next_r.instr[15]) begin
            next_r.driving = 1'b1;
        end
        if (next_r.port_cfg[scp_pkg::cfg_soft_reset_bit]) begin
            next_r.port_cfg = scp_pkg::port_cfg_reset;
            next_r.tm1 = scp_pkg::test_mode_reset;
            next_r.tm2 = scp_pkg::test_mode_reset;
        end
        // patterns move with encode clock; pn reset
        if (r.tm1[scp_pkg::tm_pn_short_reset_bit]
            || r.tm1[scp_pkg::tm_pn_long_reset_bit]) begin
            next_r.pn9 = scp_pkg::pn9_seed;
            next_r.pn23 = scp_pkg::pn23_seed;
        end else if (encode_tick) begin
            next_r.pn9 = {r.pn9[7:0], r.pn9[8] ^ r.pn9[4]};
            next_r.pn23 = {r.pn23[21:0], !(r.pn23[22] ^ r.pn23[17])};
        end
        if (encode_tick) begin
            if (!serial_mode && r.pattern_strap) begin
                next_r.out_word = scp_pkg::one_bit_high_word;
            end else if (r.tm1[3:0] == scp_pkg::tm_one_bit_high) begin
                next_r.out_word = scp_pkg::one_bit_high_word;
            end else if (r.tm1[3:0] != scp_pkg::tm_off) begin
                next_r.out_word = {r.pn9, r.pn23[6:0]};
            end else begin
                next_r.out_word = adc_word;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
            r.port_cfg <= scp_pkg::port_cfg_reset;
            r.pn9 <= scp_pkg::pn9_seed;
            r.pn23 <= scp_pkg::pn23_seed;
            r.cs1_s <= 2'b11;
            r.cs2_s <= 2'b11;
        end else begin
            r <= next_r;
        end
    end

    assign link.dev_sdio_out = r.sdo;
    assign link.dev_sdio_oe_n = !r.driving;
    assign out_word = r.out_word;
    assign bank_one_test_mode = r.tm1;
    assign bank_two_test_mode = r.tm2;
    assign serial_mode = !(r.cs1_s[1] && r.cs2_s[1]) || !r.strapped;
    assign two_lane_mode = r.lane_strap;
    assign power_down = power_down_pin;
endmodule // scp_device

// ==== hdl/scp_pkg.sv ====
// constants and types shared by both ends of the serial config port
// Function
// - sixteen-bit instruction phase opens every frame
// - two length bits set data byte count
// - first instruction bit selects read
// - sample on rising, drive on falling
// - data line turns to output quickly
// - eight-bit words, msb first, lsb optional
// - select low plus rising clock starts frame
// - selects held low stream bytes onward
// - selects high between bytes stall frame
// - both selects high ignore serial pins
// - each select gates its own bank
// - host drives both selects together
// - clock and selects are inputs
// - test mode swaps converter data for pattern
// - two bits reset pseudorandom generators
// - patterns advance only with encode clock
// - host keeps port idle when critical
// - straps read at power-up when unselected
// - power-down pin still acts in serial mode
// - clock strap gives one-bit-high pattern
// - data strap selects two or one lanes
// - soft reset restores defaults, self clears
package scp_pkg;
    localparam int instr_bits = 16;
    localparam int word_bits = 8;
    localparam int addr_bits = 13;
    localparam logic [12:0] port_cfg_addr = 13'h0000;
    localparam logic [12:0] chip_id_addr = 13'h0001;
    localparam logic [12:0] test_mode_addr = 13'h000d;
    localparam logic [7:0] port_cfg_reset = 8'h18;
    localparam logic [7:0] test_mode_reset = 8'h00;
    // arbitrary identification value
    localparam logic [7:0] chip_id_value = 8'h5a;
    localparam int cfg_lsb_first_bit = 6;
    localparam int cfg_soft_reset_bit = 5;
    localparam int cfg_soft_reset_mirror = 2;
    localparam int cfg_lsb_mirror = 1;
    localparam int tm_pn_long_reset_bit = 4;
    localparam int tm_pn_short_reset_bit = 5;
    localparam logic [3:0] tm_off = 4'h0;
    localparam logic [3:0] tm_one_bit_high = 4'hb;
    localparam logic [15:0] one_bit_high_word = 16'h8000;
    localparam logic [8:0] pn9_seed = 9'h1ff;
    localparam logic [22:0] pn23_seed = 23'h7f_ffff;
    localparam int host_half_period = 8;
    localparam int strap_settle = 2;
    typedef enum logic [1:0] {
        scp_idle_type_s = 2'b00,
        scp_instr_s = 2'b01,
        scp_data_s = 2'b11
    } scp_phase_type;
endpackage

// ==== hdl/scp_link_if.sv ====
// three-wire link between serial host and converter port
`timescale 1ns/1ns
interface scp_link_if;
    logic sclk;
    logic bank_one_select_n;
    logic bank_two_select_n;
    logic host_sdio_out;
    logic host_sdio_oe_n;
    logic dev_sdio_out;
    logic dev_sdio_oe_n;
    logic sdio;
    // wire resolution, idle level high by pull-up
    assign sdio = !dev_sdio_oe_n ? dev_sdio_out :
                  !host_sdio_oe_n ? host_sdio_out : 1'b1;
    modport host (output sclk, output bank_one_select_n,
        output bank_two_select_n, output host_sdio_out,
        output host_sdio_oe_n, input sdio);
    modport device (input sclk, input bank_one_select_n,
        input bank_two_select_n, output dev_sdio_out,
        output dev_sdio_oe_n, input sdio);
endinterface // scp_link_if

// ==== hdl/scp_host.sv ====
// serial host end: frames one read or write of up to four bytes
`timescale 1ns/1ns
module scp_host (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial link
    scp_link_if.host link,
    // request
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic [1:0] req_len,
    input wire logic [12:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    // answer
    output logic done,
    output logic [31:0] rdata
);
    typedef struct packed {
        logic [1:0] sdio_s;
        logic busy;
        logic sclk;
        logic [3:0] div;
        logic [5:0] bits_left;
        logic [4:0] instr_left;
        logic [47:0] shreg;
        logic [31:0] rdata;
        logic read;
        logic done;
        logic oe_n;
    } scp_host_state_type;

    scp_host_state_type r;
    scp_host_state_type next_r;

    always_comb begin
        next_r = r;
        next_r.sdio_s = {r.sdio_s[0], link.sdio};
        next_r.done = 1'b0;
        if (!r.busy && req_valid) begin
            next_r.busy = 1'b1;
            next_r.read = req_read;
            next_r.shreg = {req_read, req_len, req_addr, req_wdata};
            next_r.bits_left = 6'(scp_pkg::instr_bits)
                + 6'({3'd0, req_len} + 6'd1) * 6'(scp_pkg::word_bits);
            next_r.instr_left = 5'(scp_pkg::instr_bits);
            next_r.div = '0;
            next_r.oe_n = 1'b0;
        end else if (r.busy) begin
            next_r.div = r.div + 4'd1;
            // let go of the line once the last address bit is taken
            if (r.read && r.instr_left == '0 && r.div == 4'd1) begin
                next_r.oe_n = 1'b1;
            end
            if (r.div == 4'(scp_pkg::host_half_period - 1)) begin
                next_r.div = '0;
                next_r.sclk = !r.sclk;
                // capture on rising, launch on falling
                if (!r.sclk) begin
                    next_r.rdata = {r.rdata[30:0], r.sdio_s[1]};
                    next_r.bits_left = r.bits_left - 6'd1;
                    if (r.instr_left != '0) begin
                        next_r.instr_left = r.instr_left - 5'd1;
                    end
                end else begin
                    next_r.shreg = {r.shreg[46:0], 1'b0};
                    if (r.bits_left == '0) begin
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                        next_r.oe_n = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
            r.oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // clock and selects quiet between requests
    assign link.sclk = r.sclk;
    assign link.bank_one_select_n = !r.busy;
    assign link.bank_two_select_n = !r.busy;
    assign link.host_sdio_out = r.shreg[47];
    assign link.host_sdio_oe_n = r.oe_n;
    assign req_ready = !r.busy;
    assign done = r.done;
    assign rdata = r.rdata;
endmodule // scp_host

// ==== test/scp_link_sva.sv ====
// checker on the three-wire link between host and device ends
`timescale 1ns/1ns
module scp_link_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link signals
    input wire logic sclk,
    input wire logic bank_one_select_n,
    input wire logic bank_two_select_n,
    input wire logic host_sdio_out,
    input wire logic host_sdio_oe_n,
    input wire logic dev_sdio_out,
    input wire logic dev_sdio_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    logic sclk_q;
    logic [5:0] rise_cnt;
    // rising clock edges seen inside the current frame
    always_ff @(posedge mclk) begin
        if (rst || bank_one_select_n) begin
            rise_cnt <= 6'h00;
        end else if (sclk && !sclk_q && rise_cnt != 6'h3f) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
        sclk_q <= sclk;
    end
    ////////////////////////////////////////////////////////////////////////
    idle_line_free_a: assert property (
        (bank_one_select_n && bank_two_select_n) [*2] |-> dev_sdio_oe_n)
        else $error("device drives data line while deselected");
    no_contention_a: assert property (
        !(!host_sdio_oe_n && !dev_sdio_oe_n))
        else $error("both ends drive the data line");
    host_launch_low_a: assert property (
        !host_sdio_oe_n && $past(!host_sdio_oe_n)
        && $changed(host_sdio_out) |-> !sclk)
        else $error("host data changed while clock high");
    dev_launch_low_a: assert property (
        !dev_sdio_oe_n && $past(!dev_sdio_oe_n)
        && $changed(dev_sdio_out) |-> !sclk)
        else $error("device data changed while clock high");
    idle_clock_low_a: assert property (
        bank_one_select_n |-> !sclk)
        else $error("clock moves outside a frame");
    selects_paired_a: assert property (
        bank_one_select_n == bank_two_select_n)
        else $error("bank selects differ");
    clock_half_period_a: assert property (
        $rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("clock high time not eight cycles");
    turn_after_instr_a: assert property (
        $fell(dev_sdio_oe_n) |-> rise_cnt == 6'h10)
        else $error("device turned line at wrong bit");
    read_turn_cover: cover property ($fell(dev_sdio_oe_n));
endmodule // scp_link_sva

// ==== test/tb_top.sv ====
// bench joining host and device ends, register traffic over the link
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic [1:0] req_len = 2'b00;
    logic [12:0] req_addr = 13'h0000;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic req_ready;
    logic done;
    logic [31:0] rdata;
    logic encode_tick = 1'b0;
    logic [15:0] adc_word = 16'h1234;
    logic power_down_pin = 1'b0;
    logic [15:0] out_word;
    logic [7:0] bank_one_test_mode;
    logic [7:0] bank_two_test_mode;
    logic two_lane_mode;
    logic power_down;
    logic serial_mode;
    int mismatches = 0;
    int cmp_count = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) encode_tick <= ~encode_tick;
    scp_link_if link ();
    scp_host u_scp_host (.mclk(mclk), .rst(rst), .link(link),
        .req_valid(req_valid), .req_read(req_read), .req_len(req_len),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .done(done), .rdata(rdata));
    scp_device u_scp_device (.mclk(mclk), .rst(rst), .link(link),
        .encode_tick(encode_tick), .adc_word(adc_word),
        .power_down_pin(power_down_pin), .out_word(out_word),
        .bank_one_test_mode(bank_one_test_mode),
        .bank_two_test_mode(bank_two_test_mode),
        .two_lane_mode(two_lane_mode), .power_down(power_down),
        .serial_mode(serial_mode));
    scp_link_sva u_scp_link_sva (.mclk(mclk), .rst(rst), .sclk(link.sclk),
        .bank_one_select_n(link.bank_one_select_n),
        .bank_two_select_n(link.bank_two_select_n),
        .host_sdio_out(link.host_sdio_out),
        .host_sdio_oe_n(link.host_sdio_oe_n),
        .dev_sdio_out(link.dev_sdio_out),
        .dev_sdio_oe_n(link.dev_sdio_oe_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one framed transfer; waits are bounded
    task automatic xfer(input logic rd, input logic [1:0] len,
                        input logic [12:0] addr, input logic [31:0] wd);
        int n;
        req_valid = 1'b1;
        req_read = rd;
        req_len = len;
        req_addr = addr;
        req_wdata = wd;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #10;
            n++;
        end
        if (req_ready !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t host never ready", $time);
            stop_test();
        end
        @(posedge mclk);
        #10;
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            #10;
            n++;
        end
        if (done !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t transfer did not finish", $time);
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        #10;
        rst = 1'b0;
        repeat (4) @(posedge mclk);
        #10;
        check({31'h0, two_lane_mode}, 32'h0000_0001);
        check({31'h0, serial_mode}, 32'h0000_0000);
        power_down_pin = 1'b1;
        #10;
        check({31'h0, power_down}, 32'h0000_0001);
        power_down_pin = 1'b0;
        xfer(1'b1, 2'b00, scp_pkg::port_cfg_addr, 32'h0000_0000);
        check({24'h0, rdata[7:0]}, {24'h0, scp_pkg::port_cfg_reset});
        xfer(1'b1, 2'b01, scp_pkg::chip_id_addr, 32'h0000_0000);
        check({16'h0, rdata[15:0]}, {16'h0, scp_pkg::chip_id_value,
            scp_pkg::port_cfg_reset});
        xfer(1'b0, 2'b00, scp_pkg::test_mode_addr,
            {4'h0, scp_pkg::tm_one_bit_high, 24'h00_0000});
        xfer(1'b1, 2'b00, scp_pkg::test_mode_addr, 32'h0000_0000);
        check({24'h0, rdata[7:0]}, 32'h0000_000b);
        repeat (10) @(posedge mclk);
        #10;
        check({16'h0, out_word}, {16'h0, scp_pkg::one_bit_high_word});
        check({bank_one_test_mode, bank_two_test_mode},
            32'h0000_0b0b);
        xfer(1'b0, 2'b00, scp_pkg::port_cfg_addr, 32'h3c00_0000);
        xfer(1'b1, 2'b00, scp_pkg::test_mode_addr, 32'h0000_0000);
        check({24'h0, rdata[7:0]}, {24'h0, scp_pkg::test_mode_reset});
        xfer(1'b1, 2'b00, scp_pkg::port_cfg_addr, 32'h0000_0000);
        check({24'h0, rdata[7:0]}, {24'h0, scp_pkg::port_cfg_reset});
        repeat (10) @(posedge mclk);
        #10;
        check({16'h0, out_word}, {16'h0, adc_word});
        stop_test();
    end
endmodule // tb_top
